// ---- shared/motion_param_pkg.sv ----
// What this block does
// - Mark position holds a 22-bit signed two's-complement position in step units.
// - Current velocity reads as unsigned 0.28 steps per 250 ns tick.
// - Writes to current velocity or analog result are dropped and flag rejection.
// - Ramp up and ramp down rates hold unsigned 0.40 steps per tick squared.
// - Ramp up rate all ones selects infinite acceleration, no ramp.
// - In infinite acceleration mode the ramp down rate is ignored.
// - Rate and timing writes while running are dropped and flag rejection.
// - Speed ceiling holds unsigned 0.18 steps per tick, limiting top speed.
// - Speed floor holds minimum speed at two to the minus 24 per LSB.
// - Speed above full-step threshold switches drive to full-step two-phase-on.
// - Threshold at maximum code keeps microstepping always.
// - Threshold zero still means about 7.63 steps per second, not forced full step.
// - Torque code chosen by motion state: stopped, cruise, speedup, slowdown.
// - Torque code n means (n+1) times 31.25 mA, up to 4 A.
// - Decay timing: upper nibble fast decay, lower nibble fall step, (n+1)*0.5us.
// - Minimum on-time code n means (n+1)*0.5 us, up to 64 us.
// - Minimum off-time code n means (n+1)*0.5 us; code 126 is 63.5 us.
// - Analog result holds 5-bit conversion, code n is n/32 of reference.
// - Step config: sync enable bit 7, source bits 6..4, step select 2..0.
// - Step select: 000 full, 001 half, 010 quarter, 011 eighth, 1xx sixteenth.
// - Any change of step resolution resets electrical position to first microstep.
// - Sync off drives busy low during commands; sync on outputs selected clock for source codes 0 to 4, held low for codes 5 to 7.
package motion_param_pkg;
   localparam logic [4:0] ADDR_MARK     = 5'h03;
   localparam logic [4:0] ADDR_SPEED    = 5'h04;
   localparam logic [4:0] ADDR_RAMP_UP  = 5'h05;
   localparam logic [4:0] ADDR_RAMP_DN  = 5'h06;
   localparam logic [4:0] ADDR_MAXSPD   = 5'h07;
   localparam logic [4:0] ADDR_MINSPD   = 5'h08;
   localparam logic [4:0] ADDR_TQ_STOP  = 5'h09;
   localparam logic [4:0] ADDR_TQ_RUN   = 5'h0a;
   localparam logic [4:0] ADDR_TQ_UP    = 5'h0b;
   localparam logic [4:0] ADDR_TQ_DOWN  = 5'h0c;
   localparam logic [4:0] ADDR_DECAY    = 5'h0e;
   localparam logic [4:0] ADDR_TON      = 5'h0f;
   localparam logic [4:0] ADDR_TOFF     = 5'h10;
   localparam logic [4:0] ADDR_ADC      = 5'h12;
   localparam logic [4:0] ADDR_OCD      = 5'h13;
   localparam logic [4:0] ADDR_FS_THR   = 5'h15;
   localparam logic [4:0] ADDR_STEPCFG  = 5'h16;

   localparam logic [21:0] RST_MARK    = 22'h000000;
   localparam logic [11:0] RST_RATE    = 12'h08a;
   localparam logic [11:0] RATE_INF    = 12'hfff;
   localparam logic [9:0]  RST_MAXSPD  = 10'h041;
   localparam logic [12:0] RST_MINSPD  = 13'h0000;
   localparam logic [9:0]  RST_FS_THR  = 10'h027;
   localparam logic [9:0]  FS_NEVER    = 10'h3ff;
   localparam logic [6:0]  RST_TQ      = 7'h29;
   localparam logic [7:0]  RST_DECAY   = 8'h19;
   localparam logic [6:0]  RST_TON     = 7'h29;
   localparam logic [6:0]  RST_TOFF    = 7'h29;
   localparam logic [3:0]  RST_OCD     = 4'h8;
   localparam logic [7:0]  RST_STEPCFG = 8'h07;
   localparam logic [8:0]  EL_POS_HOME = 9'h000;

   localparam int SYNC_EN_BIT   = 7;
   localparam int SYNC_SEL_HI   = 6;
   localparam int SYNC_SEL_LO   = 4;
   localparam int STEP_SEL_HI   = 2;
   localparam int STEP_SEL_LO   = 0;
   localparam int SPEED_W       = 20;
   // Velocity is 0.28; threshold is 0.18 plus half LSB: align at bit 10
   localparam int FS_SHIFT      = 10;
   localparam logic [19:0] FS_HALF_LSB = 20'h00200;
   localparam logic [2:0] SYNC_SRC_LAST = 3'h4;

   typedef enum logic [3:0] {
      MOT_STOPPED  = 4'b0001,
      MOT_CRUISE   = 4'b0010,
      MOT_SPEEDUP  = 4'b0100,
      MOT_SLOWDOWN = 4'b1000
   } motion_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [21:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [21:0] mark_position;
      logic [11:0] ramp_up_rate;
      logic [11:0] ramp_down_rate;
      logic [9:0]  speed_ceiling;
      logic [12:0] speed_floor;
      logic [9:0]  fullstep_threshold;
      logic [6:0]  torque_current_stopped;
      logic [6:0]  torque_current_cruise;
      logic [6:0]  torque_current_speedup;
      logic [6:0]  torque_current_slowdown;
      logic [7:0]  decay_timing;
      logic [6:0]  min_on_time;
      logic [6:0]  min_off_time;
      logic [3:0]  overcurrent_level;
      logic [7:0]  microstep_config;
      logic [21:0] rdata;
      logic        rejected_command_flag;
      logic        el_pos_reset;
      logic        fullstep_mode;
      logic [6:0]  torque_dac;
      logic        busy_sync;
   } param_state_t;
endpackage

// ---- design/stepper_motion_parameter_regs.sv ----
`timescale 1ns/1ps
module stepper_motion_parameter_regs (
   input  wire logic                            clk_sys,
   input  wire logic                            rstn,
   input  wire motion_param_pkg::reg_req_t      req,
   input  wire logic                            flag_clear,
   input  wire logic                            motor_running,
   input  wire motion_param_pkg::motion_state_t motion_state,
   input  wire logic [19:0]                     current_velocity,
   input  wire logic [4:0]                      analog_input_result,
   input  wire logic                            cmd_busy,
   input  wire logic [7:0]                      el_pos,
   output logic [21:0]                          rdata,
   output logic                                 rejected_command_flag,
   output logic [21:0]                          mark_position,
   output logic [11:0]                          ramp_up_rate,
   output logic [11:0]                          ramp_down_eff,
   output logic                                 infinite_accel,
   output logic [9:0]                           speed_ceiling,
   output logic [12:0]                          speed_floor,
   output logic                                 fullstep_mode,
   output logic [6:0]                           torque_dac,
   output logic [3:0]                           max_fast_decay_time,
   output logic [3:0]                           max_fall_step_time,
   output logic [6:0]                           min_on_time,
   output logic [6:0]                           min_off_time,
   output logic [3:0]                           overcurrent_level,
   output logic [2:0]                           step_select,
   output logic                                 el_pos_reset,
   output logic                                 busy_sync
);
   import motion_param_pkg::*;

   param_state_t s;
   param_state_t next_s;
   logic         reject;
   logic         guarded;
   logic [19:0]  fs_level;
   logic [2:0]   sync_sel;

   // Stopped-only registers refuse writes while the motor runs
   always_comb begin
      guarded = (req.addr == ADDR_RAMP_UP) || (req.addr == ADDR_RAMP_DN) ||
                (req.addr == ADDR_DECAY) || (req.addr == ADDR_TON) ||
                (req.addr == ADDR_TOFF);
      reject  = req.wr && ((req.addr == ADDR_SPEED) ||
                (req.addr == ADDR_ADC) || (guarded && motor_running));
   end

   assign fs_level = {s.fullstep_threshold, FS_SHIFT'(0)} | FS_HALF_LSB;
   assign sync_sel = s.microstep_config[SYNC_SEL_HI:SYNC_SEL_LO];

   always_comb begin
      next_s = s;
      next_s.el_pos_reset = 1'b0;
      if (req.wr && !reject) begin
         case (req.addr)
            ADDR_MARK:    next_s.mark_position = req.wdata;
            ADDR_RAMP_UP: next_s.ramp_up_rate = req.wdata[11:0];
            ADDR_RAMP_DN: next_s.ramp_down_rate = req.wdata[11:0];
            ADDR_MAXSPD:  next_s.speed_ceiling = req.wdata[9:0];
            ADDR_MINSPD:  next_s.speed_floor = req.wdata[12:0];
            ADDR_FS_THR:  next_s.fullstep_threshold = req.wdata[9:0];
            ADDR_TQ_STOP: next_s.torque_current_stopped = req.wdata[6:0];
            ADDR_TQ_RUN:  next_s.torque_current_cruise = req.wdata[6:0];
            ADDR_TQ_UP:   next_s.torque_current_speedup = req.wdata[6:0];
            ADDR_TQ_DOWN: next_s.torque_current_slowdown = req.wdata[6:0];
            ADDR_DECAY:   next_s.decay_timing = req.wdata[7:0];
            ADDR_TON:     next_s.min_on_time = req.wdata[6:0];
            ADDR_TOFF:    next_s.min_off_time = req.wdata[6:0];
            ADDR_OCD:     next_s.overcurrent_level = req.wdata[3:0];
            ADDR_STEPCFG: begin
               next_s.microstep_config = req.wdata[7:0];
               next_s.el_pos_reset = req.wdata[STEP_SEL_HI:STEP_SEL_LO] !=
                  s.microstep_config[STEP_SEL_HI:STEP_SEL_LO];
            end
            default: ;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            ADDR_MARK:    next_s.rdata = s.mark_position;
            ADDR_SPEED:   next_s.rdata = 22'(current_velocity);
            ADDR_RAMP_UP: next_s.rdata = 22'(s.ramp_up_rate);
            ADDR_RAMP_DN: next_s.rdata = 22'(s.ramp_down_rate);
            ADDR_MAXSPD:  next_s.rdata = 22'(s.speed_ceiling);
            ADDR_MINSPD:  next_s.rdata = 22'(s.speed_floor);
            ADDR_FS_THR:  next_s.rdata = 22'(s.fullstep_threshold);
            ADDR_TQ_STOP: next_s.rdata = 22'(s.torque_current_stopped);
            ADDR_TQ_RUN:  next_s.rdata = 22'(s.torque_current_cruise);
            ADDR_TQ_UP:   next_s.rdata = 22'(s.torque_current_speedup);
            ADDR_TQ_DOWN: next_s.rdata = 22'(s.torque_current_slowdown);
            ADDR_DECAY:   next_s.rdata = 22'(s.decay_timing);
            ADDR_TON:     next_s.rdata = 22'(s.min_on_time);
            ADDR_TOFF:    next_s.rdata = 22'(s.min_off_time);
            ADDR_ADC:     next_s.rdata = 22'(analog_input_result);
            ADDR_OCD:     next_s.rdata = 22'(s.overcurrent_level);
            ADDR_STEPCFG: next_s.rdata = 22'(s.microstep_config);
            default:      next_s.rdata = '0;
         endcase
      end
      // Set beats clear so a rejection in the clear cycle is kept
      if (reject) begin
         next_s.rejected_command_flag = 1'b1;
      end else if (flag_clear) begin
         next_s.rejected_command_flag = 1'b0;
      end
      // Maximum code never switches; zero still compares at half LSB
      next_s.fullstep_mode = (s.fullstep_threshold != FS_NEVER) &&
                             (current_velocity > fs_level);
      case (motion_state)
         MOT_STOPPED:  next_s.torque_dac = s.torque_current_stopped;
         MOT_CRUISE:   next_s.torque_dac = s.torque_current_cruise;
         MOT_SPEEDUP:  next_s.torque_dac = s.torque_current_speedup;
         MOT_SLOWDOWN: next_s.torque_dac = s.torque_current_slowdown;
         default:      next_s.torque_dac = s.torque_current_stopped;
      endcase
      if (!s.microstep_config[SYNC_EN_BIT]) begin
         next_s.busy_sync = !cmd_busy;
      end else if (sync_sel > SYNC_SRC_LAST) begin
         next_s.busy_sync = 1'b0;
      end else begin
         next_s.busy_sync = el_pos[3'd7 - sync_sel];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s.mark_position           <= RST_MARK;
         s.ramp_up_rate            <= RST_RATE;
         s.ramp_down_rate          <= RST_RATE;
         s.speed_ceiling           <= RST_MAXSPD;
         s.speed_floor             <= RST_MINSPD;
         s.fullstep_threshold      <= RST_FS_THR;
         s.torque_current_stopped  <= RST_TQ;
         s.torque_current_cruise   <= RST_TQ;
         s.torque_current_speedup  <= RST_TQ;
         s.torque_current_slowdown <= RST_TQ;
         s.decay_timing            <= RST_DECAY;
         s.min_on_time             <= RST_TON;
         s.min_off_time            <= RST_TOFF;
         s.overcurrent_level       <= RST_OCD;
         s.microstep_config        <= RST_STEPCFG;
         s.rdata                   <= '0;
         s.rejected_command_flag   <= 1'b0;
         s.el_pos_reset            <= 1'b0;
         s.fullstep_mode           <= 1'b0;
         s.torque_dac              <= RST_TQ;
         s.busy_sync               <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata                 = s.rdata;
   assign rejected_command_flag = s.rejected_command_flag;
   assign mark_position         = s.mark_position;
   assign ramp_up_rate          = s.ramp_up_rate;
   assign infinite_accel        = (s.ramp_up_rate == RATE_INF);
   // Engine sees the same all-ones rate for slowdown, so no ramp either way
   assign ramp_down_eff = infinite_accel ? RATE_INF : s.ramp_down_rate;
   assign speed_ceiling         = s.speed_ceiling;
   assign speed_floor           = s.speed_floor;
   assign fullstep_mode         = s.fullstep_mode;
   assign torque_dac            = s.torque_dac;
   assign max_fast_decay_time   = s.decay_timing[7:4];
   assign max_fall_step_time    = s.decay_timing[3:0];
   assign min_on_time           = s.min_on_time;
   assign min_off_time          = s.min_off_time;
   assign overcurrent_level     = s.overcurrent_level;
   // Codes 1xx all collapse to sixteenth stepping
   assign step_select = s.microstep_config[STEP_SEL_HI] ? 3'h4 :
                        s.microstep_config[STEP_SEL_HI:STEP_SEL_LO];
   assign el_pos_reset          = s.el_pos_reset;
   assign busy_sync             = s.busy_sync;

   logic fullstep_threshold_max;
   assign fullstep_threshold_max = (s.fullstep_threshold == FS_NEVER);

   chk_reject_write: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      req.wr && (req.addr == ADDR_SPEED || req.addr == ADDR_ADC)
      |=> rejected_command_flag)
      else $error("read-only write not flagged");
   chk_running_guard: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      req.wr && motor_running && req.addr == ADDR_RAMP_UP
      |=> $stable(ramp_up_rate) && rejected_command_flag)
      else $error("running write took effect");
   chk_set_wins: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      reject && flag_clear |=> rejected_command_flag)
      else $error("clear beat set");
   chk_flag_clear: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      flag_clear && !reject |=> !rejected_command_flag)
      else $error("flag not cleared");
   chk_mark_write: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      req.wr && req.addr == ADDR_MARK |=> mark_position == $past(req.wdata))
      else $error("mark not stored");
   chk_speed_read: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      req.rd && req.addr == ADDR_SPEED
      |=> rdata == 22'($past(current_velocity)))
      else $error("speed read wrong");
   chk_infinite_dec: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      infinite_accel |-> ramp_down_eff == RATE_INF)
      else $error("slowdown rate not ignored");
   chk_never_full: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      $past(fullstep_threshold_max) |-> !fullstep_mode)
      else $error("full step at max threshold");
   chk_torque_stop: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      motion_state == MOT_STOPPED && $stable(s.torque_current_stopped)
      |=> torque_dac == $past(s.torque_current_stopped))
      else $error("wrong torque source");
   // Raw field compare: 1xx to 1yy also restarts the sine table
   chk_step_reset: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      el_pos_reset |-> s.microstep_config[STEP_SEL_HI:STEP_SEL_LO] !=
         $past(s.microstep_config[STEP_SEL_HI:STEP_SEL_LO]))
      else $error("spurious position reset");
   chk_busy_low: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !s.microstep_config[SYNC_EN_BIT] && cmd_busy
      && $stable(s.microstep_config) |=> !busy_sync)
      else $error("busy not low");

   cov_reject: cover property (@(posedge clk_sys) disable iff (!rstn)
      reject && motor_running);
   cov_fullstep: cover property (@(posedge clk_sys) disable iff (!rstn)
      $rose(fullstep_mode));
   cov_step_change: cover property (@(posedge clk_sys) disable iff (!rstn)
      el_pos_reset);
   cov_sync_clock: cover property (@(posedge clk_sys) disable iff (!rstn)
      s.microstep_config[SYNC_EN_BIT] && $rose(busy_sync));
endmodule

// ---- verif/motion_engine_model.sv ----
`timescale 1ns/1ps
module motion_engine_model (
   input  wire logic                            clk_sys,
   input  wire logic                            run,
   input  wire motion_param_pkg::motion_state_t st,
   input  wire logic [19:0]                     vel,
   input  wire logic [4:0]                      adc,
   input  wire logic                            busy,
   input  wire logic                            el_pos_reset,
   output motion_param_pkg::motion_state_t      motion_state,
   output logic                                 motor_running,
   output logic [19:0]                          current_velocity,
   output logic [4:0]                           analog_input_result,
   output logic                                 cmd_busy,
   output logic [7:0]                           el_pos
);
   import motion_param_pkg::*;
   initial begin
      motion_state = MOT_STOPPED;
      {motor_running, current_velocity, analog_input_result} = '0;
      {cmd_busy, el_pos} = '0;
   end
   // Moves on the falling edge so the block never samples mid-change
   always @(negedge clk_sys) begin
      motor_running <= run;
      motion_state <= run ? st : MOT_STOPPED;
      current_velocity <= run ? vel : 20'h00000;
      analog_input_result <= adc;
      cmd_busy <= busy;
      if (el_pos_reset) begin
         el_pos <= 8'h00;
      end else if (run) begin
         el_pos <= el_pos + 8'h01;
      end
   end
endmodule

// ---- verif/stepper_motion_parameter_regs_tb_top.sv ----
`timescale 1ns/1ps
module stepper_motion_parameter_regs_tb_top;
   import motion_param_pkg::*;
   logic          clk_sys = 1'b0;
   logic          rstn = 1'b0;
   reg_req_t      req = '0;
   logic          flag_clear = 1'b0;
   logic          run = 1'b0;
   logic          busy = 1'b0;
   motion_state_t st = MOT_CRUISE;
   logic [19:0]   vel = 20'h00000;
   logic [4:0]    adc = 5'h0b;
   motion_state_t motion_state;
   logic          motor_running, cmd_busy, rejected_command_flag;
   logic          infinite_accel, fullstep_mode, el_pos_reset, busy_sync;
   logic [19:0]   current_velocity;
   logic [4:0]    analog_input_result;
   logic [7:0]    el_pos;
   logic [21:0]   rdata, mark_position, d;
   logic [11:0]   ramp_up_rate, ramp_down_eff;
   logic [9:0]    speed_ceiling, t;
   logic [12:0]   speed_floor;
   logic [6:0]    torque_dac, min_on_time, min_off_time;
   logic [3:0]    max_fast_decay_time, max_fall_step_time, overcurrent_level;
   logic [2:0]    step_select, c;
   logic [19:0]   v;
   logic [31:0]   seed = 32'h00000031;
   int            checks = 0, n_mismatch = 0, n_pulse = 0, i, p;
   logic [4:0]    ta [15] = '{ADDR_MARK, ADDR_RAMP_UP, ADDR_RAMP_DN,
      ADDR_MAXSPD, ADDR_MINSPD, ADDR_TQ_STOP, ADDR_TQ_RUN, ADDR_TQ_UP,
      ADDR_TQ_DOWN, ADDR_DECAY, ADDR_TON, ADDR_TOFF, ADDR_OCD, ADDR_FS_THR,
      ADDR_STEPCFG};
   int            tw [15] = '{22, 12, 12, 10, 13, 7, 7, 7, 7, 8, 7, 7, 4, 10, 8};
   logic [21:0]   tr [15] = '{RST_MARK, 22'(RST_RATE), 22'(RST_RATE),
      22'(RST_MAXSPD), 22'(RST_MINSPD), 22'(RST_TQ), 22'(RST_TQ), 22'(RST_TQ),
      22'(RST_TQ), 22'(RST_DECAY), 22'(RST_TON), 22'(RST_TOFF),
      22'(RST_OCD), 22'(RST_FS_THR), 22'(RST_STEPCFG)};
   logic [21:0]   shadow [15];

   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (el_pos_reset === 1'b1) n_pulse <= n_pulse + 1;
   end

   stepper_motion_parameter_regs uut (.clk_sys, .rstn, .req, .flag_clear,
      .motor_running, .motion_state, .current_velocity, .analog_input_result,
      .cmd_busy, .el_pos, .rdata, .rejected_command_flag, .mark_position,
      .ramp_up_rate, .ramp_down_eff, .infinite_accel, .speed_ceiling,
      .speed_floor, .fullstep_mode, .torque_dac, .max_fast_decay_time,
      .max_fall_step_time, .min_on_time, .min_off_time, .overcurrent_level,
      .step_select, .el_pos_reset, .busy_sync);
   motion_engine_model partner (.clk_sys, .run, .st, .vel, .adc, .busy,
      .el_pos_reset, .motion_state, .motor_running, .current_velocity,
      .analog_input_result, .cmd_busy, .el_pos);

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [21:0] msk(input int k);
      return ~(22'h3fffff << tw[k]);
   endfunction
   function automatic logic prot(input logic [4:0] a);
      return a inside {ADDR_RAMP_UP, ADDR_RAMP_DN, ADDR_DECAY, ADDR_TON,
                       ADDR_TOFF};
   endfunction
   task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmpb(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // One idle cycle before each access keeps strobes single-assigned
   task automatic acc_bus(input logic w, input logic [4:0] a,
                          input logic [21:0] dt);
      @(negedge clk_sys);
      req = '{wr: w, rd: !w, addr: a, wdata: dt};
      @(negedge clk_sys);
      req = '0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [21:0] e);
      acc_bus(1'b0, a, 22'h000000);
      cmp(rdata, e);
   endtask
   task automatic clr();
      @(negedge clk_sys);
      flag_clear = 1'b1;
      @(negedge clk_sys);
      flag_clear = 1'b0;
   endtask
   task automatic settle();
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_mismatch++;
      close_out();
   end

   initial begin
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      for (int k = 0; k < 15; k++) begin
         shadow[k] = tr[k];
         rd_chk(ta[k], tr[k]);
      end
      rd_chk(5'h0d, 22'h000000);
      rd_chk(5'h1f, 22'h000000);
      done("reset");
      // All-ones first for the top codes, then random fill
      for (int k = 0; k < 60; k++) begin
         i = (k < 15) ? k : int'(rnd() % 15);
         d = (k < 15) ? msk(i) : rnd() & msk(i);
         if (ta[i] == ADDR_STEPCFG) d[3] = 1'b1;
         acc_bus(1'b1, ta[i], d);
         shadow[i] = d;
         rd_chk(ta[i], d);
      end
      cmp(mark_position, shadow[0]);
      cmp(22'(ramp_up_rate), shadow[1]);
      cmp(22'(speed_ceiling), shadow[3]);
      cmp(22'(speed_floor), shadow[4]);
      cmp(22'({max_fast_decay_time, max_fall_step_time}), shadow[9]);
      cmp(22'(min_on_time), shadow[10]);
      cmp(22'(min_off_time), shadow[11]);
      cmp(22'(overcurrent_level), shadow[12]);
      cmpb(rejected_command_flag, 1'b0);
      done("readback");
      run <= 1'b1;
      vel <= 20'habcde;
      settle();
      acc_bus(1'b1, ADDR_SPEED, 22'h3fffff);
      cmpb(rejected_command_flag, 1'b1);
      rd_chk(ADDR_SPEED, 22'habcde);
      clr();
      cmpb(rejected_command_flag, 1'b0);
      @(negedge clk_sys);
      flag_clear = 1'b1;
      acc_bus(1'b1, ADDR_ADC, 22'h00001f);
      flag_clear = 1'b0;
      cmpb(rejected_command_flag, 1'b1);
      rd_chk(ADDR_ADC, 22'h00000b);
      clr();
      done("readonly");
      for (int k = 0; k < 15; k++) begin
         d = ~shadow[k] & msk(k);
         if (ta[k] == ADDR_STEPCFG) d[3] = 1'b1;
         acc_bus(1'b1, ta[k], d);
         if (!prot(ta[k])) shadow[k] = d;
         cmpb(rejected_command_flag, prot(ta[k]));
         rd_chk(ta[k], shadow[k]);
         clr();
      end
      done("running");
      for (int k = 0; k < 12; k++) begin
         t = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'(rnd());
         v = (k == 0) ? 20'hfffff : {t, 10'h000} + 20'h1ff + 20'(rnd() % 3);
         acc_bus(1'b1, ADDR_FS_THR, 22'(t));
         vel <= v;
         settle();
         cmpb(fullstep_mode, t != 10'h3ff && v > {t, 10'h200});
      end
      done("fullstep");
      run <= 1'b0;
      settle();
      acc_bus(1'b1, ADDR_RAMP_UP, 22'hfff);
      acc_bus(1'b1, ADDR_RAMP_DN, 22'h456);
      cmpb(infinite_accel, 1'b1);
      cmp(22'(ramp_down_eff), 22'hfff);
      acc_bus(1'b1, ADDR_RAMP_UP, 22'hffe);
      cmpb(infinite_accel, 1'b0);
      cmp(22'(ramp_down_eff), 22'h456);
      done("infinite");
      for (int k = 0; k < 4; k++) begin
         shadow[5 + k] = rnd() & 22'h7f;
         acc_bus(1'b1, ta[5 + k], shadow[5 + k]);
      end
      for (int k = 0; k < 4; k++) begin
         run <= (k != 0);
         st <= motion_state_t'(4'h1 << k);
         settle();
         cmp(22'(torque_dac), shadow[5 + k]);
      end
      done("torque");
      run <= 1'b0;
      acc_bus(1'b1, ADDR_STEPCFG, 22'h00000f);
      settle();
      for (int k = 0; k < 9; k++) begin
         c = (k == 8) ? 3'h7 : 3'(k);
         p = n_pulse;
         acc_bus(1'b1, ADDR_STEPCFG, 22'({5'b00001, c}));
         settle();
         cmp(22'(step_select), 22'(c[2] ? 3'h4 : c));
         cmp(22'(n_pulse - p), 22'(k != 8));
      end
      done("stepmode");
      for (int k = 0; k < 8; k++) begin
         run <= 1'b1;
         repeat (int'(rnd() % 40) + 1) @(negedge clk_sys);
         run <= 1'b0;
         acc_bus(1'b1, ADDR_STEPCFG, 22'({1'b1, 3'(k), 4'b1100}));
         settle();
         cmpb(busy_sync, (k <= 4) ? el_pos[7 - k] : 1'b0);
      end
      acc_bus(1'b1, ADDR_STEPCFG, 22'h00000c);
      for (int k = 0; k < 2; k++) begin
         busy <= 1'(k);
         settle();
         cmpb(busy_sync, k == 0);
      end
      done("sync");
      close_out();
   end
endmodule
